// ### verilog/flash_cmd_checker.sv
// module: flash command launch checks, erase-verify sequencing and invalid-read capture
// What this block does
// - program/erase before divider set raises access error
// - unknown command code raises access error, discarded
// - reads of busy block return invalid data
// - invalid read with both fault flags clear sets both, captures address
// - code 01 verifies whole flash, index 000
// - verify-all and verify-block need index 000
// - verify sets error bits; protection flag untouched
// - code 02 picks block by address 22:16
// - verify-block checks whole program area (any block 7C-7F) or data block erased
// - invalid block address raises access error
// - code 03 takes address high, low, count
// - verify-section needs index 010
// - section address outside program flash is error
// - misaligned section start raises access error
// - section crossing 256 kbyte boundary is error
// - section verify blocked in locked mode
// - clear complete flag launches; set when done
// - verify-section checks counted phrases erased
// - 01 all, 02 block, 03 counted section
//
// Implementation choices: the register offsets and the APB slave port.
module flash_cmd_checker
	import fev_pkg::*;
#(
	parameter int P_PHRASE_CNT = P_PHRASES // program area size in phrases
)(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cpuRdStrobe,
	input  wire logic [22:0] cpuRdAddr,
	output logic             cpuRdInvalid,
	output logic             memRdEn,
	output logic [22:0]      memRdAddr,
	input  wire logic [63:0] memRdData,
	input  wire logic        memRdSbe,
	input  wire logic        memRdDbe
);
	verify_if vif ();                         // link to the verify walker

	logic [6:0]  divVal_q, divVal_d;          // clock divider value
	logic        divLoaded_q, divLoaded_d;    // divider written since reset
	logic        command_complete_flag_q, command_complete_flag_d;              // command complete flag
	logic        access_error_flag_q, access_error_flag_d;          // access error flag
	logic        protection_violation_flag_q, protection_violation_flag_d;          // protection violation flag
	logic        mgUp_q, mgUp_d;              // any verify error
	logic        mgLo_q, mgLo_d;              // non-correctable verify error
	logic        sfd_q, sfd_d;                // single fault detect
	logic        dfd_q, dfd_d;                // double fault detect
	logic [22:0] eccAddr_q, eccAddr_d;        // captured invalid read address
	logic [2:0]  ix_q, ix_d;                  // parameter index
	logic [15:0] param_q [NUM_PARAM];         // parameter words
	logic [15:0] param_d [NUM_PARAM];
	logic        secLock_q, secLock_d;        // section verify not permitted
	seq_e        seq_q, seq_d;                // sequencer state
	logic        allNext_q, allNext_d;        // data area still to walk
	logic        vStart_q, vStart_d;          // walker start pulse
	logic [22:0] vBase_q, vBase_d;            // walker base
	logic [15:0] vCount_q, vCount_d;          // walker count
	logic [31:0] prdata_q, prdata_d;          // registered read data
	logic        apbWr;                       // write taken this edge
	logic        mapped;                      // address decodes
	logic [31:0] rdMux;                       // read data selection
	logic        launchReq;                   // software asks for a launch
	logic        launch;                      // launch accepted for checking
	logic        launchFail;                  // launch checks failed
	logic [7:0]  code;                        // launched command code
	logic [6:0]  blkHi;                       // address bits 22:16
	logic [22:0] secAddr;                     // full section start address
	logic [23:0] secEnd;                      // last byte of the section
	logic        blkIsP;                      // block code names program area
	logic        codeValid;                   // code is a known command
	logic        progErase;                   // code programs or erases
	logic        inP;                         // read hits program area
	logic        inD;                         // read hits data area
	logic        invRd;                       // read hits the busy block
	verify_engine u_engine (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.vif       (vif.engine),
		.memRdEn   (memRdEn),
		.memRdAddr (memRdAddr),
		.memRdData (memRdData),
		.memRdSbe  (memRdSbe),
		.memRdDbe  (memRdDbe)
	);
	assign vif.start = vStart_q;
	assign vif.base  = vBase_q;
	assign vif.count = vCount_q;
	// apb decode: zero wait states, error on unmapped offsets
	assign pready  = 1'b1;
	assign apbWr   = psel && penable && pwrite;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = prdata_q;
	// read data mux; the capture data register always reads zero
	always_comb begin
		mapped = 1'b1;
		rdMux  = 32'h0000_0000;
		case (paddr)
			OFS_CLKDIV:  rdMux = {24'h00_0000, divLoaded_q, divVal_q};
			OFS_STATUS: begin
				rdMux[BIT_COMMAND_COMPLETE_FLAG]   = command_complete_flag_q;
				rdMux[BIT_ACCESS_ERROR_FLAG] = access_error_flag_q;
				rdMux[BIT_PROTECTION_VIOLATION_FLAG] = protection_violation_flag_q;
				rdMux[BIT_MGUP]   = mgUp_q;
				rdMux[BIT_MGLO]   = mgLo_q;
			end
			OFS_FAULT: begin
				rdMux[BIT_DFD] = dfd_q;
				rdMux[BIT_SFD] = sfd_q;
			end
			OFS_INDEX:   rdMux = {29'h0000_0000, ix_q};
			OFS_PARAM:   rdMux = (ix_q < 3'(NUM_PARAM)) ? {16'h0000, param_q[ix_q]} : 32'h0;
			OFS_ECCADDR: rdMux = {9'h000, eccAddr_q};
			OFS_ECCDATA: rdMux = 32'h0000_0000;
			OFS_CONFIG:  rdMux = {31'h0000_0000, secLock_q};
			default:     mapped = 1'b0;
		endcase
	end
	// decode of the loaded command
	assign code      = param_q[IX_CODE][15:8];
	assign blkHi     = param_q[IX_CODE][6:0];
	assign secAddr   = {blkHi, param_q[IX_ADDR]};
	assign secEnd    = {1'b0, secAddr} + {5'h00, param_q[IX_COUNT], 3'h0} - 24'h00_0001;
	assign blkIsP    = (blkHi >= P_BLK_LO) && (blkHi <= P_BLK_HI);
	assign launchReq = apbWr && (paddr == OFS_STATUS) && pwdata[BIT_COMMAND_COMPLETE_FLAG] && command_complete_flag_q;
	assign launch    = launchReq && !access_error_flag_q && !protection_violation_flag_q;

	// code classes; neighbouring commands are accepted but finish at once
	assign progErase = code inside {8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h11, 8'h12};
	assign codeValid = progErase
		|| (code inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h0C, 8'h0D, 8'h0E, 8'h10});
	// launch checks per command
	always_comb begin
		case (code)
			CMD_EV_ALL: launchFail = (ix_q != IX_CODE);
			CMD_EV_BLK: launchFail = (ix_q != IX_CODE) || !(blkIsP || blkHi == D_BLK);
			CMD_EV_SEC: launchFail = (ix_q != IX_COUNT)
				|| secLock_q
				|| (secAddr[22:18] != P_WINDOW)
				|| (secAddr[2:0] != 3'h0)
				|| (param_q[IX_COUNT] == 16'h0000)
				|| (secEnd[23:18] != {1'b0, secAddr[22:18]});
			default:    launchFail = !codeValid || (progErase && !divLoaded_q);
		endcase
	end
	// invalid read while the walked block is busy
	assign inP          = (cpuRdAddr[22:18] == P_WINDOW);
	assign inD          = (cpuRdAddr[22:16] == D_BLK);
	assign invRd        = cpuRdStrobe && !command_complete_flag_q
		&& (((seq_q == SEQ_RUNP) && inP) || ((seq_q == SEQ_RUND) && inD));
	assign cpuRdInvalid = invRd;

	// next-state logic for registers and the verify sequencer
	always_comb begin
		divVal_d    = divVal_q;
		divLoaded_d = divLoaded_q;
		command_complete_flag_d      = command_complete_flag_q;
		access_error_flag_d    = access_error_flag_q;
		protection_violation_flag_d    = protection_violation_flag_q;
		mgUp_d      = mgUp_q;
		mgLo_d      = mgLo_q;
		sfd_d       = sfd_q;
		dfd_d       = dfd_q;
		eccAddr_d   = eccAddr_q;
		ix_d        = ix_q;
		param_d     = param_q;
		secLock_d   = secLock_q;
		seq_d       = seq_q;
		allNext_d   = allNext_q;
		vStart_d    = 1'b0;
		vBase_d     = vBase_q;
		vCount_d    = vCount_q;
		prdata_d    = prdata_q;
		// read data is sampled in the setup phase
		if (psel && !penable) begin
			prdata_d = rdMux;
		end
		// software writes; the parameter array is frozen while busy
		if (apbWr) begin
			case (paddr)
				OFS_CLKDIV: begin
					divVal_d    = pwdata[6:0];
					divLoaded_d = 1'b1;
				end
				OFS_STATUS: begin
					// write one clears the error flags
					if (pwdata[BIT_ACCESS_ERROR_FLAG]) access_error_flag_d = 1'b0;
					if (pwdata[BIT_PROTECTION_VIOLATION_FLAG]) protection_violation_flag_d = 1'b0;
				end
				OFS_FAULT: begin
					if (pwdata[BIT_DFD]) dfd_d = 1'b0;
					if (pwdata[BIT_SFD]) sfd_d = 1'b0;
				end
				OFS_INDEX:  ix_d = pwdata[2:0];
				OFS_PARAM: begin
					if (command_complete_flag_q && ix_q < 3'(NUM_PARAM)) param_d[ix_q] = pwdata[15:0];
				end
				OFS_CONFIG: secLock_d = pwdata[0];
				default:    ;
			endcase
		end
		// launch: a failed check leaves the complete flag set
		if (launch) begin
			mgUp_d = 1'b0;
			mgLo_d = 1'b0;
			if (launchFail) begin
				access_error_flag_d = 1'b1;
			end else begin
				command_complete_flag_d   = 1'b0;
				vStart_d = 1'b1;
				case (code)
					CMD_EV_ALL: begin
						seq_d     = SEQ_RUNP;
						allNext_d = 1'b1;
						vBase_d   = P_BASE;
						vCount_d  = 16'(P_PHRASE_CNT);
					end
					CMD_EV_BLK: begin
						seq_d     = blkIsP ? SEQ_RUNP : SEQ_RUND;
						allNext_d = 1'b0;
						vBase_d   = blkIsP ? P_BASE : D_BASE;
						vCount_d  = blkIsP ? 16'(P_PHRASE_CNT) : D_PHRASES;
					end
					CMD_EV_SEC: begin
						seq_d     = SEQ_RUNP;
						allNext_d = 1'b0;
						vBase_d   = secAddr;
						vCount_d  = param_q[IX_COUNT];
					end
					default: begin
						seq_d    = SEQ_FINISH;
						vStart_d = 1'b0;
					end
				endcase
			end
		end
		// sequencer walks, folds results into the verify bits
		case (seq_q)
			SEQ_IDLE: ;
			SEQ_RUNP, SEQ_RUND: begin
				if (vif.done) begin
					mgUp_d = mgUp_q | vif.anyErr;
					mgLo_d = mgLo_q | vif.uncorrErr;
					if (allNext_q) begin
						// verify-all continues into the data area
						allNext_d = 1'b0;
						seq_d     = SEQ_RUND;
						vStart_d  = 1'b1;
						vBase_d   = D_BASE;
						vCount_d  = D_PHRASES;
					end else begin
						seq_d  = SEQ_IDLE;
						command_complete_flag_d = 1'b1;
					end
				end
			end
			SEQ_FINISH: begin
				seq_d  = SEQ_IDLE;
				command_complete_flag_d = 1'b1;
			end
			default: seq_d = SEQ_IDLE;
		endcase
		// fault capture only while both fault flags are clear; a same-cycle clear does not let it in
		if (invRd && !sfd_q && !dfd_q) begin
			sfd_d     = 1'b1;
			dfd_d     = 1'b1;
			eccAddr_d = cpuRdAddr;
		end
	end

	// state registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			divVal_q    <= 7'h00;
			divLoaded_q <= 1'b0;
			command_complete_flag_q      <= 1'b1;
			access_error_flag_q    <= 1'b0;
			protection_violation_flag_q    <= 1'b0;
			mgUp_q      <= 1'b0;
			mgLo_q      <= 1'b0;
			sfd_q       <= 1'b0;
			dfd_q       <= 1'b0;
			eccAddr_q   <= 23'h00_0000;
			ix_q        <= 3'h0;
			for (int i = 0; i < NUM_PARAM; i++) param_q[i] <= 16'h0000;
			secLock_q   <= 1'b0;
			seq_q       <= SEQ_IDLE;
			allNext_q   <= 1'b0;
			vStart_q    <= 1'b0;
			vBase_q     <= 23'h00_0000;
			vCount_q    <= 16'h0000;
			prdata_q    <= 32'h0000_0000;
		end else begin
			divVal_q    <= divVal_d;
			divLoaded_q <= divLoaded_d;
			command_complete_flag_q      <= command_complete_flag_d;
			access_error_flag_q    <= access_error_flag_d;
			protection_violation_flag_q    <= protection_violation_flag_d;
			mgUp_q      <= mgUp_d;
			mgLo_q      <= mgLo_d;
			sfd_q       <= sfd_d;
			dfd_q       <= dfd_d;
			eccAddr_q   <= eccAddr_d;
			ix_q        <= ix_d;
			param_q     <= param_d;
			secLock_q   <= secLock_d;
			seq_q       <= seq_d;
			allNext_q   <= allNext_d;
			vStart_q    <= vStart_d;
			vBase_q     <= vBase_d;
			vCount_q    <= vCount_d;
			prdata_q    <= prdata_d;
		end
	end

	// checks on the launch and fault behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence s_okLaunch;
		launch && !launchFail && code == CMD_EV_ALL;
	endsequence
	sequence s_walkP;
		(seq_q == SEQ_RUNP && !command_complete_flag_q && allNext_q);
	endsequence

	property p_badCode;
		launch && !codeValid |=> access_error_flag_q && command_complete_flag_q;
	endproperty
	a_badCode: assert property (p_badCode) else $error("bad code not refused");
	property p_divInit;
		launch && progErase && !divLoaded_q |=> access_error_flag_q && seq_q == SEQ_IDLE;
	endproperty
	a_divInit: assert property (p_divInit) else $error("divider check missed");
	property p_allIndex;
		launch && code == CMD_EV_ALL && ix_q != IX_CODE |=> access_error_flag_q && command_complete_flag_q;
	endproperty
	a_allIndex: assert property (p_allIndex) else $error("verify-all index check");
	property p_secAlign;
		launch && code == CMD_EV_SEC && secAddr[2:0] != 3'h0 |=> access_error_flag_q;
	endproperty
	a_secAlign: assert property (p_secAlign) else $error("misaligned section taken");
	property p_failNoRun;
		launch && launchFail |=> command_complete_flag_q && !mgUp_q && !mgLo_q ##1 !vif.start;
	endproperty
	a_failNoRun: assert property (p_failNoRun) else $error("failed launch ran");
	property p_allStarts;
		s_okLaunch |=> s_walkP ##1 (vif.count == 16'(P_PHRASE_CNT));
	endproperty
	a_allStarts: assert property (p_allStarts) else $error("verify-all walk not started");
	property p_fpviolQuiet;
		!protection_violation_flag_q |=> !protection_violation_flag_q;
	endproperty
	a_fpviolQuiet: assert property (p_fpviolQuiet) else $error("protection flag set");
	property p_invRead;
		invRd && !sfd_q && !dfd_q |=> sfd_q && dfd_q && eccAddr_q == $past(cpuRdAddr);
	endproperty
	a_invRead: assert property (p_invRead) else $error("invalid read not captured");
	property p_busyRead;
		cpuRdStrobe && !command_complete_flag_q && seq_q == SEQ_RUNP && inP |-> cpuRdInvalid;
	endproperty
	a_busyRead: assert property (p_busyRead) else $error("busy read not flagged");
	property p_ccifBack;
		seq_q == SEQ_FINISH |=> command_complete_flag_q && seq_q == SEQ_IDLE;
	endproperty
	a_ccifBack: assert property (p_ccifBack) else $error("complete flag not restored");
endmodule

// ### verilog/fev_pkg.sv
// package: register map, command codes, flash geometry and sequencer states
package fev_pkg;
	// register byte offsets on the apb slave
	localparam logic [7:0] OFS_CLKDIV  = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_FAULT   = 8'h08;
	localparam logic [7:0] OFS_INDEX   = 8'h0C;
	localparam logic [7:0] OFS_PARAM   = 8'h10;
	localparam logic [7:0] OFS_ECCADDR = 8'h14;
	localparam logic [7:0] OFS_ECCDATA = 8'h18;
	localparam logic [7:0] OFS_CONFIG  = 8'h1C;
	// bit positions in the status, fault and clock divider registers
	localparam int BIT_COMMAND_COMPLETE_FLAG   = 7;
	localparam int BIT_ACCESS_ERROR_FLAG = 5;
	localparam int BIT_PROTECTION_VIOLATION_FLAG = 4;
	localparam int BIT_MGUP   = 1;
	localparam int BIT_MGLO   = 0;
	localparam int BIT_DFD    = 1;
	localparam int BIT_SFD    = 0;
	localparam int BIT_DIVLD  = 7;
	// command codes handled here
	localparam logic [7:0] CMD_EV_ALL = 8'h01;
	localparam logic [7:0] CMD_EV_BLK = 8'h02;
	localparam logic [7:0] CMD_EV_SEC = 8'h03;
	// parameter word indices
	localparam logic [2:0] IX_CODE  = 3'h0;
	localparam logic [2:0] IX_ADDR  = 3'h1;
	localparam logic [2:0] IX_COUNT = 3'h2;
	localparam int         NUM_PARAM = 6;
	// flash geometry: program area is one 256 kbyte window
	localparam logic [4:0]  P_WINDOW   = 5'h1F;
	localparam logic [6:0]  P_BLK_LO   = 7'h7C;
	localparam logic [6:0]  P_BLK_HI   = 7'h7F;
	localparam logic [6:0]  D_BLK      = 7'h10;
	localparam logic [22:0] P_BASE     = 23'h7C_0000;
	localparam logic [22:0] D_BASE     = 23'h10_0000;
	localparam int          P_PHRASES  = 32768;
	localparam logic [15:0] D_PHRASES  = 16'h0400;
	localparam logic [63:0] ERASED     = 64'hFFFF_FFFF_FFFF_FFFF;
	// sequencer states
	typedef enum logic [1:0] {SEQ_IDLE = 2'b00, SEQ_RUNP = 2'b01,
		SEQ_RUND = 2'b10, SEQ_FINISH = 2'b11} seq_e;
endpackage

// ### verilog/verify_if.sv
// interface: launch and result of one linear erase-verify walk
interface verify_if;
	logic        start;     // one-cycle pulse, begins a walk
	logic [22:0] base;      // first phrase address
	logic [15:0] count;     // phrases to read
	logic        done;      // one-cycle pulse, walk finished
	logic        anyErr;    // any error seen in the walk
	logic        uncorrErr; // a non-correctable error seen
	modport ctrl   (output start, base, count, input done, anyErr, uncorrErr);
	modport engine (input start, base, count, output done, anyErr, uncorrErr);
endinterface

// ### verilog/verify_engine.sv
// module: walks a run of phrases and checks that each one reads erased
module verify_engine
	import fev_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	verify_if.engine         vif,
	output logic             memRdEn,
	output logic [22:0]      memRdAddr,
	input  wire logic [63:0] memRdData,
	input  wire logic        memRdSbe,
	input  wire logic        memRdDbe
);
	logic [22:0] addr_q, addr_d;   // next phrase to read
	logic [15:0] left_q, left_d;   // phrases still to issue
	logic        pend_q, pend_d;   // read data arrives this cycle
	logic        any_q, any_d;     // error accumulator
	logic        unc_q, unc_d;     // non-correctable accumulator
	logic        done_q, done_d;   // completion pulse

	// one read per cycle, data checked one cycle later
	always_comb begin
		addr_d  = addr_q;
		left_d  = left_q;
		any_d   = any_q;
		unc_d   = unc_q;
		memRdEn = 1'b0;
		if (vif.start) begin
			// fresh walk clears the accumulators
			addr_d = vif.base;
			left_d = vif.count;
			any_d  = 1'b0;
			unc_d  = 1'b0;
		end else if (left_q != 16'h0000) begin
			memRdEn = 1'b1;
			addr_d  = addr_q + 23'h00_0008;
			left_d  = left_q - 16'h0001;
		end
		if (pend_q) begin
			// not erased or any ecc hit counts as an error
			any_d = any_d | (memRdData != ERASED) | memRdSbe | memRdDbe;
			unc_d = unc_d | memRdDbe;
		end
		pend_d = memRdEn;
		done_d = pend_q && (left_q == 16'h0000) && !vif.start;
	end

	// state registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_q <= 23'h00_0000;
			left_q <= 16'h0000;
			pend_q <= 1'b0;
			any_q  <= 1'b0;
			unc_q  <= 1'b0;
			done_q <= 1'b0;
		end else begin
			addr_q <= addr_d;
			left_q <= left_d;
			pend_q <= pend_d;
			any_q  <= any_d;
			unc_q  <= unc_d;
			done_q <= done_d;
		end
	end

	assign memRdAddr     = addr_q;
	assign vif.done      = done_q;
	assign vif.anyErr    = any_q;
	assign vif.uncorrErr = unc_q;
endmodule

// ### test/flash_cmd_checker_tb.sv
// testbench: apb-driven checks of flash command launch and erase-verify sequencing
module flash_cmd_checker_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fev_pkg::*;
	localparam int PCNT = 16;        // shortened program area, in phrases
	logic        sys_clk = 1'b0;     // 100 MHz clock
	logic        rst_b = 1'b0;       // active-low reset
	logic        psel = 1'b0;        // apb select
	logic        penable = 1'b0;     // apb access phase
	logic        pwrite = 1'b0;      // apb direction
	logic [7:0]  paddr = 8'h00;      // apb byte address
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cpuRdStrobe = 1'b0; // cpu flash read pulse
	logic [22:0] cpuRdAddr = 23'h00_0000;
	logic        cpuRdInvalid;
	logic        memRdEn;
	logic [22:0] memRdAddr;
	logic [63:0] memRdData = 64'h0000_0000_0000_0000;
	logic        memRdSbe = 1'b0;
	logic        memRdDbe = 1'b0;
	logic [22:0] sbeAddr = 23'h7F_FFFF; // phrase that answers with a correctable error
	logic [22:0] dbeAddr = 23'h7F_FFFF; // phrase that answers with a hard error
	logic        lastErr;            // pslverr of the last transfer
	logic [22:0] rdLast;             // last array address read
	int          rdCount = 0;        // array reads seen so far
	int          err_total = 0;
	int          n_compared = 0;

	// clock generation
	always #5 sys_clk = ~sys_clk;

	flash_cmd_checker #(.P_PHRASE_CNT(PCNT)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuRdStrobe(cpuRdStrobe),
		.cpuRdAddr(cpuRdAddr), .cpuRdInvalid(cpuRdInvalid), .memRdEn(memRdEn),
		.memRdAddr(memRdAddr), .memRdData(memRdData), .memRdSbe(memRdSbe),
		.memRdDbe(memRdDbe));

	// array stand-in: answers one cycle after each read, garbles the bus otherwise
	always @(posedge sys_clk) begin
		memRdData <= memRdEn ? ERASED : ~memRdData;
		memRdSbe <= memRdEn && (memRdAddr == sbeAddr);
		memRdDbe <= memRdEn && (memRdAddr == dbeAddr);
		if (memRdEn) begin
			rdCount <= rdCount + 1;
			rdLast <= memRdAddr;
		end
	end

	// verdict and end of run
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// one comparison, reported at once on mismatch
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// a bounded wait ran out
	task automatic hang(input string what);
		err_total++;
		$display("wrong value at %0t: %s timed out", $time, what);
		wrap_up();
	endtask

	// one apb transfer: setup, then access until pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (n > 50) hang("pready");
		end while (pready !== 1'b1);
		r = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// register write and checked register read
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		apb(1'b0, a, 32'h0000_0000, r);
		chk(r, exp, "register read");
	endtask

	// load three parameter words, leave the index at lastIx, then launch
	task automatic cmd(input logic [7:0] code, input logic [6:0] hi, input logic [15:0] lo,
		input logic [15:0] cnt, input logic [2:0] lastIx);
		wr(OFS_INDEX, 32'h0000_0000);
		wr(OFS_PARAM, {16'h0000, code, 1'b0, hi});
		wr(OFS_INDEX, 32'h0000_0001);
		wr(OFS_PARAM, {16'h0000, lo});
		wr(OFS_INDEX, 32'h0000_0002);
		wr(OFS_PARAM, {16'h0000, cnt});
		wr(OFS_INDEX, {29'h0000_0000, lastIx});
		wr(OFS_STATUS, 32'h0000_0080);
	endtask

	// refused launch: error flag up, complete flag never drops; then cleared
	task automatic refused();
		rd(OFS_STATUS, 32'h0000_00A0);
		wr(OFS_STATUS, 32'h0000_0020);
		rd(OFS_STATUS, 32'h0000_0080);
	endtask

	// accepted walk: busy first, then done with verify bits, read count and last address
	task automatic run(input logic [1:0] mg, input int nRd, input logic [22:0] lastA,
		int c0);
		logic [31:0] r;
		int n;
		apb(1'b0, OFS_STATUS, 32'h0000_0000, r);
		chk({31'h0, r[BIT_COMMAND_COMPLETE_FLAG]}, 32'h0000_0000, "busy flag");
		n = 0;
		while (r[BIT_COMMAND_COMPLETE_FLAG] !== 1'b1) begin
			apb(1'b0, OFS_STATUS, 32'h0000_0000, r);
			n++;
			if (n > 1000) hang("command complete");
		end
		chk(r, {24'h00_0000, 8'h80 | {6'h00, mg}}, "final status");
		chk(rdCount - c0, nRd, "array read count");
		chk({9'h000, rdLast}, {9'h000, lastA}, "last array address");
	endtask

	// reset state and an unmapped offset
	task automatic t_reset();
		rd(OFS_STATUS, 32'h0000_0080);
		rd(OFS_FAULT, 32'h0000_0000);
		rd(8'h20, 32'h0000_0000);
		chk({31'h0, lastErr}, 32'h0000_0001, "slave error");
	endtask

	// program before divider set, then unknown codes
	task automatic t_launch_codes();
		logic [7:0] bad [5] = '{8'h00, 8'h05, 8'h0F, 8'h13, 8'hFF};
		cmd(8'h06, 7'h7C, 16'h0000, 16'h0000, 3'h5);
		refused();
		wr(OFS_CLKDIV, 32'h0000_0001);
		rd(OFS_CLKDIV, 32'h0000_0081);
		cmd(8'h06, 7'h7C, 16'h0000, 16'h0000, 3'h5);
		rd(OFS_STATUS, 32'h0000_0080);
		foreach (bad[i]) begin
			cmd(bad[i], 7'h7C, 16'h0000, 16'h0000, 3'h0);
			refused();
		end
	endtask

	// wrong index, bad block, bad section address, alignment, boundary, mode
	task automatic t_launch_checks();
		cmd(CMD_EV_ALL, 7'h00, 16'h0000, 16'h0000, 3'h1);
		refused();
		cmd(CMD_EV_BLK, D_BLK, 16'h0000, 16'h0000, 3'h2);
		refused();
		cmd(CMD_EV_SEC, 7'h7C, 16'h0000, 16'h0001, 3'h0);
		refused();
		cmd(CMD_EV_BLK, 7'h20, 16'h0000, 16'h0000, 3'h0);
		refused();
		cmd(CMD_EV_SEC, D_BLK, 16'h0000, 16'h0001, 3'h2);
		refused();
		cmd(CMD_EV_SEC, 7'h7C, 16'h0004, 16'h0001, 3'h2);
		refused();
		cmd(CMD_EV_SEC, 7'h7F, 16'hFFF8, 16'h0002, 3'h2);
		refused();
		wr(OFS_CONFIG, 32'h0000_0001);
		cmd(CMD_EV_SEC, 7'h7C, 16'h0000, 16'h0001, 3'h2);
		refused();
		wr(OFS_CONFIG, 32'h0000_0000);
	endtask

	// verify-all, with a cpu read of the busy data block in mid-walk
	task automatic t_all();
		int c0;
		int n;
		c0 = rdCount;
		cmd(CMD_EV_ALL, 7'h00, 16'h0000, 16'h0000, 3'h0);
		n = 0;
		while (memRdAddr[22:16] !== D_BLK) begin
			@(posedge sys_clk);
			n++;
			if (n > 300) hang("data walk");
		end
		cpuRdStrobe <= 1'b1;
		cpuRdAddr <= 23'h10_0040;
		@(posedge sys_clk);
		chk({31'h0, cpuRdInvalid}, 32'h0000_0001, "invalid read");
		cpuRdAddr <= 23'h7C_0000;
		@(posedge sys_clk);
		chk({31'h0, cpuRdInvalid}, 32'h0000_0000, "read of idle block");
		cpuRdAddr <= 23'h10_0080;
		@(posedge sys_clk);
		cpuRdStrobe <= 1'b0;
		run(2'b00, PCNT + 1024, 23'h10_1FF8, c0);
		rd(OFS_FAULT, 32'h0000_0003);
		rd(OFS_ECCADDR, 32'h0010_0040);
		rd(OFS_ECCDATA, 32'h0000_0000);
		wr(OFS_FAULT, 32'h0000_0003);
		rd(OFS_FAULT, 32'h0000_0000);
	endtask

	// block verify with a hard error, section verify with a soft error
	task automatic t_blk_sec();
		dbeAddr <= 23'h10_0028;
		cmd(CMD_EV_BLK, D_BLK, 16'h0000, 16'h0000, 3'h0);
		run(2'b11, 1024, 23'h10_1FF8, rdCount);
		dbeAddr <= 23'h7F_FFFF;
		sbeAddr <= 23'h7C_0018;
		cmd(CMD_EV_SEC, 7'h7C, 16'h0010, 16'h0003, 3'h2);
		run(2'b10, 3, 23'h7C_0020, rdCount);
		sbeAddr <= 23'h7F_FFFF;
	endtask

	// main sequence
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_reset();
		t_launch_codes();
		t_launch_checks();
		t_all();
		t_blk_sec();
		wrap_up();
	end
endmodule
